/* hdl/pcd_map.vh */
`ifndef PCD_MAP_VH
`define PCD_MAP_VH

`define PCD_PINS          16
`define PCD_AW            8
`define PCD_ZERO16        16'h0000
`define PCD_ZERO32        32'h00000000
// register byte offsets, one aligned word each
`define PCD_OFS_CTRL      8'h00
`define PCD_OFS_RISE      8'h04
`define PCD_OFS_FALL      8'h08
`define PCD_OFS_FLAG      8'h0C
`define PCD_OFS_PULLUP    8'h10
`define PCD_OFS_PULLDOWN  8'h14
`define PCD_OFS_IRQ_STAT  8'h18
`define PCD_OFS_IRQ_EN    8'h1C
`define PCD_OFS_IRQ_CLR   8'h20
`define PCD_OFS_PINS      8'h24
// control register fields
`define PCD_CTRL_ON_BIT   0
// interrupt status bits
`define PCD_IRQ_W         2
`define PCD_IRQ_CHANGE    0
`define PCD_IRQ_SPURIOUS  1
// ahb encodings
`define PCD_HTRANS_NONSEQ 2'h2
`define PCD_HTRANS_SEQ    2'h3
`define PCD_HRESP_OKAY    1'h0

`endif

/* hdl/pcd_sync.v */
`default_nettype none
// two-stage synchroniser per pin
module pcd_sync (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [15:0] d_in,
    output wire [15:0] q_out
);
    reg [15:0] meta_r;
    reg [15:0] sync_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= 16'h0000;
            sync_r <= 16'h0000;
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;
endmodule // pcd_sync
`default_nettype wire

/* hdl/pcd_edge.v */
`default_nettype none
`include "pcd_map.vh"
// per-pin edge qualification against the enables
module pcd_edge (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   module_on,
    input  wire [`PCD_PINS-1:0]   pin_sync,
    input  wire [`PCD_PINS-1:0]   rise_en,
    input  wire [`PCD_PINS-1:0]   fall_en,
    output wire [`PCD_PINS-1:0]   hit
);
    reg [`PCD_PINS-1:0] prev_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            prev_r <= `PCD_ZERO16;
        end else begin
            prev_r <= pin_sync;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PCD_PINS; g = g + 1) begin : g_pin
            wire rise_w;
            wire fall_w;
            assign rise_w = pin_sync[g] & ~prev_r[g];
            assign fall_w = ~pin_sync[g] & prev_r[g];
            // either enable alone, both, or neither
            assign hit[g] = module_on &
                ((rise_en[g] & rise_w) |
                 (fall_en[g] & fall_w));
        end
    endgenerate
endmodule // pcd_edge
`default_nettype wire

/* hdl/pcd_top.v */
// What this block does
// - falling enable set: falling edge sets flag
// - falling enable clear: falling edges ignored
// - both enables: both edges; neither: off
// - enable write while on may fire spuriously
// - flag set by enabled rising or falling edge
// - writing zero clears flag; zero means none
// - writing one to flag does nothing
// - pullup bit one turns pullup on
// - pulldown bit one turns pulldown on
// - sixteen-bit pin registers, all registers reset to zero
// - rising enable set: rising edge sets flag
`default_nettype none
`include "pcd_map.vh"
module pcd_top (
    input  wire        SYS_CLK,
    input  wire        NRST,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire        HREADY,
    input  wire [31:0] HWDATA,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    input  wire [15:0] PIN_IN,
    output reg  [15:0] PIN_PULLUP_EN,
    output reg  [15:0] PIN_PULLDOWN_EN,
    output reg         IRQ
);
    reg  [15:0]              rising_edge_enable_r;
    reg  [15:0]              falling_edge_enable_r;
    reg  [15:0]              change_flag_r;
    reg  [15:0]              change_flag_nxt;
    reg                      module_on_r;
    reg  [`PCD_IRQ_W-1:0]    irq_stat_r;
    reg  [`PCD_IRQ_W-1:0]    irq_stat_nxt;
    reg  [`PCD_IRQ_W-1:0]    irq_en_r;
    reg                      wr_pend_r;
    reg  [`PCD_AW-1:0]       addr_r;
    wire [15:0]              pin_sync;
    wire [15:0]              hit;
    wire                     addr_ph;
    wire                     wr_ctrl;
    wire                     wr_rise;
    wire                     wr_fall;
    wire                     wr_flag;
    wire                     wr_up;
    wire                     wr_down;
    wire                     wr_ien;
    wire                     wr_iclr;
    wire                     spurious;
    reg  [31:0]              rd_val;

    pcd_sync u_sync (
        .clk   (SYS_CLK),
        .rst_n (NRST),
        .d_in  (PIN_IN),
        .q_out (pin_sync)
    );

    pcd_edge u_edge (
        .clk       (SYS_CLK),
        .rst_n     (NRST),
        .module_on (module_on_r),
        .pin_sync  (pin_sync),
        .rise_en   (rising_edge_enable_r),
        .fall_en   (falling_edge_enable_r),
        .hit       (hit)
    );

    // zero-wait slave: every access completes in its data phase
    assign addr_ph = HSEL & HREADY &
        ((HTRANS == `PCD_HTRANS_NONSEQ) | (HTRANS == `PCD_HTRANS_SEQ));

    assign wr_ctrl = wr_pend_r & (addr_r == `PCD_OFS_CTRL);
    assign wr_rise = wr_pend_r & (addr_r == `PCD_OFS_RISE);
    assign wr_fall = wr_pend_r & (addr_r == `PCD_OFS_FALL);
    assign wr_flag = wr_pend_r & (addr_r == `PCD_OFS_FLAG);
    assign wr_up   = wr_pend_r & (addr_r == `PCD_OFS_PULLUP);
    assign wr_down = wr_pend_r & (addr_r == `PCD_OFS_PULLDOWN);
    assign wr_ien  = wr_pend_r & (addr_r == `PCD_OFS_IRQ_EN);
    assign wr_iclr = wr_pend_r & (addr_r == `PCD_OFS_IRQ_CLR);

    // changing an edge enable while on can look like an edge; flag it
    assign spurious = module_on_r & (wr_rise | wr_fall);

    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            wr_pend_r <= 1'b0;
            addr_r    <= {`PCD_AW{1'b0}};
        end else begin
            wr_pend_r <= addr_ph & HWRITE;
            if (addr_ph) begin
                addr_r <= HADDR[`PCD_AW-1:0];
            end
        end
    end

    // hardware set wins over a software clear in the same cycle
    always @* begin
        change_flag_nxt = change_flag_r;
        if (wr_flag) begin
            change_flag_nxt = change_flag_r & HWDATA[15:0];
        end
        change_flag_nxt = change_flag_nxt | hit;
    end

    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (wr_iclr) begin
            irq_stat_nxt = irq_stat_r & ~HWDATA[`PCD_IRQ_W-1:0];
        end
        if (|hit) begin
            irq_stat_nxt[`PCD_IRQ_CHANGE] = 1'b1;
        end
        if (spurious) begin
            irq_stat_nxt[`PCD_IRQ_SPURIOUS] = 1'b1;
        end
    end

    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            rising_edge_enable_r  <= `PCD_ZERO16;
            falling_edge_enable_r <= `PCD_ZERO16;
            change_flag_r         <= `PCD_ZERO16;
            PIN_PULLUP_EN         <= `PCD_ZERO16;
            PIN_PULLDOWN_EN       <= `PCD_ZERO16;
            module_on_r           <= 1'b0;
            irq_stat_r            <= {`PCD_IRQ_W{1'b0}};
            irq_en_r              <= {`PCD_IRQ_W{1'b0}};
            IRQ                   <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                module_on_r <= HWDATA[`PCD_CTRL_ON_BIT];
            end
            if (wr_rise) begin
                rising_edge_enable_r <= HWDATA[15:0];
            end
            if (wr_fall) begin
                falling_edge_enable_r <= HWDATA[15:0];
            end
            if (wr_up) begin
                PIN_PULLUP_EN <= HWDATA[15:0];
            end
            if (wr_down) begin
                PIN_PULLDOWN_EN <= HWDATA[15:0];
            end
            if (wr_ien) begin
                irq_en_r <= HWDATA[`PCD_IRQ_W-1:0];
            end
            change_flag_r <= change_flag_nxt;
            irq_stat_r    <= irq_stat_nxt;
            IRQ           <= |(irq_stat_nxt & irq_en_r);
        end
    end

    always @* begin
        case (HADDR[`PCD_AW-1:0])
            `PCD_OFS_CTRL:     rd_val = {31'h00000000, module_on_r};
            `PCD_OFS_RISE:     rd_val = {16'h0000, rising_edge_enable_r};
            `PCD_OFS_FALL:     rd_val = {16'h0000, falling_edge_enable_r};
            `PCD_OFS_FLAG:     rd_val = {16'h0000, change_flag_r};
            `PCD_OFS_PULLUP:   rd_val = {16'h0000, PIN_PULLUP_EN};
            `PCD_OFS_PULLDOWN: rd_val = {16'h0000, PIN_PULLDOWN_EN};
            `PCD_OFS_IRQ_STAT: rd_val = {30'h00000000, irq_stat_r};
            `PCD_OFS_IRQ_EN:   rd_val = {30'h00000000, irq_en_r};
            `PCD_OFS_PINS:     rd_val = {16'h0000, pin_sync};
            default:           rd_val = `PCD_ZERO32;
        endcase
    end

    // read data is latched at the address phase and stands in the data phase
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            HRDATA    <= `PCD_ZERO32;
            HREADYOUT <= 1'b1;
            HRESP     <= `PCD_HRESP_OKAY;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= `PCD_HRESP_OKAY;
            if (addr_ph & ~HWRITE) begin
                HRDATA <= rd_val;
            end
        end
    end
endmodule // pcd_top
`default_nettype wire

/* test/pcd_props.sv */
`default_nettype none
module pcd_props (
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [15:0] PIN_IN,
    input wire logic [15:0] PIN_PULLUP_EN,
    input wire logic [15:0] PIN_PULLDOWN_EN,
    input wire logic        IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic go = HSEL & HREADY & HTRANS[1];
    wire logic wr = go & HWRITE;
    wire logic rd = go & ~HWRITE;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    zero_wait_a: assert property (HREADYOUT)
        else $error("wait state inserted");
    okay_resp_a: assert property (!HRESP)
        else $error("error response");
    pullup_write_a: assert property (
        !$stable(PIN_PULLUP_EN) |-> $past(wr, 2))
        else $error("pull-up moved without a write");
    pulldown_write_a: assert property (
        !$stable(PIN_PULLDOWN_EN) |-> $past(wr, 2))
        else $error("pull-down moved without a write");
    // a pin edge lands three edges after the first flop takes it
    irq_cause_a: assert property ($rose(IRQ) |->
        $past(PIN_IN, 4) != $past(PIN_IN, 5) ||
        $past(PIN_IN, 3) != $past(PIN_IN, 4) ||
        $past(wr, 2) || $past(wr, 3))
        else $error("interrupt without a cause");
    irq_clear_a: assert property (
        $fell(IRQ) |-> $past(wr, 2) || $past(wr, 3))
        else $error("interrupt dropped without a write");
    rdata_upper_a: assert property (HRDATA[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    rdata_hold_a: assert property (
        !$stable(HRDATA) |-> $past(rd))
        else $error("read data moved without a read");
endmodule // pcd_props
`default_nettype wire

/* test/pcd_pins_model.sv */
`default_nettype none
module pcd_pins_model (
    input wire logic        clk,
    input wire logic [15:0] drv_en,
    input wire logic [15:0] drv_val,
    input wire logic [15:0] pu,
    input wire logic [15:0] pd,
    output var logic [15:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = 16'h0000;
    // an undriven pin with no pull wanders every cycle, never holds
    always @(posedge clk) begin
        pin <= (drv_en & drv_val) | (~drv_en & pu)
             | (~drv_en & ~pu & ~pd & ~pin);
    end
endmodule // pcd_pins_model
`default_nettype wire

/* test/testbench.sv */
`default_nettype none
`include "pcd_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        SYS_CLK = 1'b0;
    logic        NRST = 1'b0;
    logic        HSEL = 1'b0;
    logic        HWRITE = 1'b0;
    logic [1:0]  HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h00000000;
    logic [31:0] HWDATA = 32'h00000000;
    logic [15:0] drv = 16'h0000;
    logic [31:0] r;
    wire logic [31:0] HRDATA;
    wire logic        HREADYOUT;
    wire logic        HRESP;
    wire logic        IRQ;
    wire logic [15:0] pins;
    wire logic [15:0] pu;
    wire logic [15:0] pd;
    int num_errors = 0;
    int check_count = 0;
    pcd_top u_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIN_IN(pins),
        .PIN_PULLUP_EN(pu), .PIN_PULLDOWN_EN(pd), .IRQ(IRQ));
    pcd_pins_model u_pins (.clk(SYS_CLK), .drv_en(16'h000F),
        .drv_val(drv), .pu(pu), .pd(pd), .pin(pins));
    initial forever #5 SYS_CLK = ~SYS_CLK;
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h000000, a};
        HTRANS <= `PCD_HTRANS_NONSEQ;
        HWRITE <= w;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h00000000);
        chk($sformatf("reg %h", a), e, r);
    endtask
    task automatic pulse(input logic [15:0] v);
        drv <= v;
        repeat (6) @(posedge SYS_CLK);
    endtask
    task final_report;
        $display("TB: %0d checks, %0d errors", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge SYS_CLK);
        NRST <= 1'b1;
        @(posedge SYS_CLK);
        for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h00000000);
        rdc(8'h3C, 32'h00000000);
        $display("TB: reset test done");
        wr(`PCD_OFS_PULLUP, 32'hFFFFA5C3);
        wr(`PCD_OFS_PULLDOWN, 32'h00005A3C);
        rdc(`PCD_OFS_PULLUP, 32'h0000A5C3);
        chk("pullup pins", 32'h0000A5C3, {16'h0000, pu});
        chk("pulldown pins", 32'h00005A3C, {16'h0000, pd});
        rdc(`PCD_OFS_PULLDOWN, 32'h00005A3C);
        // driven low nibble reads 0, the rest follow their pull-ups
        rdc(`PCD_OFS_PINS, 32'h0000A5C0);
        $display("TB: pull test done");
        // enables go in while the module is off, so no stray event
        wr(`PCD_OFS_RISE, 32'h00000006);
        wr(`PCD_OFS_FALL, 32'h00000005);
        wr(`PCD_OFS_IRQ_EN, 32'h00000001);
        wr(`PCD_OFS_CTRL, 32'h00000001);
        pulse(16'h000F);
        rdc(`PCD_OFS_FLAG, 32'h00000006);
        chk("irq", 32'h00000001, {31'h0, IRQ});
        wr(`PCD_OFS_FLAG, 32'hFFFF0000);
        rdc(`PCD_OFS_FLAG, 32'h00000000);
        wr(`PCD_OFS_FLAG, 32'h0000FFFF);
        rdc(`PCD_OFS_FLAG, 32'h00000000);
        pulse(16'h0000);
        rdc(`PCD_OFS_FLAG, 32'h00000005);
        wr(`PCD_OFS_FLAG, 32'h00000004);
        rdc(`PCD_OFS_FLAG, 32'h00000004);
        $display("TB: edge test done");
        wr(`PCD_OFS_IRQ_EN, 32'h00000000);
        rdc(`PCD_OFS_IRQ_STAT, 32'h00000001);
        chk("irq masked", 32'h00000000, {31'h0, IRQ});
        wr(`PCD_OFS_IRQ_CLR, 32'h00000003);
        rdc(`PCD_OFS_IRQ_STAT, 32'h00000000);
        wr(`PCD_OFS_RISE, 32'h00000008);
        rdc(`PCD_OFS_IRQ_STAT, 32'h00000002);
        $display("TB: irq test done");
        // reset in mid-run must bring rise enable, flag and both pull registers back to zero
        NRST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        NRST <= 1'b1;
        @(posedge SYS_CLK);
        rdc(`PCD_OFS_RISE, 32'h00000000);
        rdc(`PCD_OFS_FLAG, 32'h00000000);
        rdc(`PCD_OFS_PULLUP, 32'h00000000);
        chk("pulldown reset", 32'h00000000, {16'h0000, pd});
        $display("TB: reset again test done");
        final_report;
    end
    initial begin
        repeat (3000) @(posedge SYS_CLK);
        num_errors++;
        final_report;
    end
endmodule // testbench
bind pcd_top pcd_props u_props (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .PIN_IN(PIN_IN), .PIN_PULLUP_EN(PIN_PULLUP_EN),
    .PIN_PULLDOWN_EN(PIN_PULLDOWN_EN), .IRQ(IRQ));
`default_nettype wire
